// ---- shared/fpm_pkg.sv ----
// Constants and carrier types for the nonvolatile page map block.
// Assumes a single bus clock and a byte-wide array behind the decode.
package fpm_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [3:0] FPM_IDX_DIV   = 4'h0;
    localparam logic [3:0] FPM_IDX_SEC   = 4'h1;
    localparam logic [3:0] FPM_IDX_KCFG  = 4'h3;
    localparam logic [3:0] FPM_IDX_PROT  = 4'h4;
    localparam logic [3:0] FPM_IDX_STAT  = 4'h5;
    localparam logic [3:0] FPM_IDX_CMD   = 4'h6;
    localparam logic [3:0] FPM_IDX_TAH   = 4'h8;
    localparam logic [3:0] FPM_IDX_TAL   = 4'h9;
    localparam logic [3:0] FPM_IDX_TDH   = 4'ha;
    localparam logic [3:0] FPM_IDX_TDL   = 4'hb;

    // Reset values (SEC and PROT held until the reset sequence loads the array bytes) and write masks
    localparam logic [7:0] FPM_RST_DIV   = 8'h00;
    localparam logic [7:0] FPM_RST_SEC   = 8'h00;
    localparam logic [7:0] FPM_RST_PROT  = 8'hff;
    localparam logic [7:0] FPM_RST_KCFG  = 8'h00;
    localparam logic [7:0] FPM_CMD_MASK  = 8'h65;
    localparam logic [7:0] FPM_KCFG_MASK = 8'he0;

    // Field positions
    localparam int FPM_DIV_LD   = 7;
    localparam int FPM_KCFG_KEY = 5;
    localparam int FPM_PR_OPEN  = 7;
    localparam int FPM_PR_HDIS  = 5;
    localparam int FPM_PR_LDIS  = 2;
    localparam int FPM_ST_PVIOL = 5;
    localparam logic [1:0] FPM_KEY_ON = 2'b10;

    // Configuration field, array-relative
    localparam logic [16:0] FPM_CFG_PROT = 17'h1ff0d;
    localparam logic [16:0] FPM_CFG_SEC  = 17'h1ff0f;
    localparam logic [12:0] FPM_KEY_HI   = 13'h1ff0;
    localparam logic [2:0]  FPM_KEY_TOP  = 3'h7;

    // Page numbers within the array and page-select encodings
    localparam logic [2:0] FPM_PG_LOW  = 3'h6;
    localparam logic [2:0] FPM_PG_TOP  = 3'h7;
    localparam logic [4:0] FPM_PS_BASE = 5'h07;
    localparam logic [1:0] FPM_PS_GAP  = 2'h0;

    // Region limits inside a 16 Kbyte page, indexed by the size field
    localparam logic [3:0][13:0] FPM_LO_END =
        {14'h2000, 14'h1000, 14'h0800, 14'h0400};
    localparam logic [3:0][13:0] FPM_HI_BEG =
        {14'h0000, 14'h2000, 14'h3000, 14'h3800};

    // AXI responses
    localparam logic [1:0] FPM_OKAY   = 2'b00;
    localparam logic [1:0] FPM_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        FPM_RS_ADDP = 3'b000,
        FPM_RS_WTP  = 3'b001,
        FPM_RS_GETP = 3'b010,
        FPM_RS_WTS  = 3'b011,
        FPM_RS_GETS = 3'b100,
        FPM_RS_RUN  = 3'b101
    } fpm_rs_e;

    typedef struct packed {
        logic        valid;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  page;
    } fpm_cpu_s;

    typedef struct packed {
        logic        sel;
        logic        we;
        logic        viol;
        logic        key_wr;
        logic [16:0] addr;
    } fpm_arr_s;

    typedef struct packed {
        fpm_rs_e     rs;
        logic [7:0]  div;
        logic [7:0]  sec;
        logic [7:0]  kcfg;
        logic [7:0]  prot;
        logic        pviol;
        logic [7:0]  cmd;
        logic [7:0]  tah;
        logic [7:0]  tal;
        logic [7:0]  tdh;
        logic [7:0]  tdl;
        logic        aw_got;
        logic        aw_ok;
        logic [3:0]  aw_idx;
        logic        w_got;
        logic        w_en;
        logic [7:0]  wdat;
        logic        awrdy;
        logic        wrdy;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arrdy;
        logic        rvalid;
        logic [7:0]  rdat;
        logic [1:0]  rresp;
        logic        hold;
        logic        cfg_re;
        logic [16:0] cfg_addr;
        fpm_arr_s    arr;
    } fpm_st_s;

endpackage : fpm_pkg

// ---- logic/fpm_top.sv ----
// Page decode, protection regions and control registers of the
// 96 Kbyte nonvolatile array.
// Assumes the CPU request and the array read data come from logic on
// clk_sys; the array returns cfg_rd_data the cycle after it sees cfg_re.
`timescale 1ns/1ps

// Functional notes
// - Block has no chip pins; every connection stays inside the chip.
// - Array answers CPU addresses 0x4000-0xFFFF as three 16K pages.
// - Window 0x8000-0xBFFF goes to the page named by page select.
// - Page select 0x3A-0x3F picks array pages ascending from 0x08000.
// - 0x4000 window equals select 0x3E; 0xC000 window equals 0x3F.
// - Protection setting can lock the whole array globally.
// - Lower region starts at 0x4000, ends 0x43FF/47FF/4FFF/5FFF.
// - Higher region ends at 0xFFFF, starts F800/F000/E000/C000.
// - Remaining addresses form a third, separately protected region.
// - Unlock key sits at 0xFF00-0xFF07; 0xFF08-0xFF0C reserved.
// - Default protection byte sits at 0xFF0D; 0xFF0E reserved.
// - Security byte sits at 0xFF0F.
// - Sixteen byte registers decode at offsets 0x0 to 0xF.
// - Offsets 0x2, 0x7, 0xC-0xF are test-reserved and read zero.
// - Reset sequence loads security register from byte 0xFF0F.
// - Reset sequence loads protection register from byte 0xFF0D.
module fpm_top
    import fpm_pkg::*;
#(
    parameter int AW = 8
)(
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire logic          ce,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire fpm_cpu_s      cpu_req,
    output fpm_arr_s           arr_req,
    output logic               cpu_hold,
    output logic               cfg_re,
    output logic [16:0]        cfg_addr,
    input  wire logic [7:0]    cfg_rd_data
);

    // Upper address bits are needed to spot unmapped offsets
    if (AW < 7)
    begin : g_aw_chk
        $error("fpm_top: AW must be at least 7");
    end

    fpm_st_s r;
    fpm_st_s nxt;

    // Combinational decode values
    logic [3:0]  rd_idx;
    logic        rd_ok;
    logic [7:0]  rd_val;
    logic [2:0]  pg;
    logic        pg_ok;
    logic [16:0] aa;
    logic        lo_hit;
    logic        hi_hit;
    logic        prot_hit;
    logic [7:0]  wv;
    logic [7:0]  pr;

    // Register read mux; reserved indices fall to zero
    always_comb
    begin
        rd_idx = s_axi_araddr[5:2];
        rd_ok  = (s_axi_araddr[AW-1:6] == '0);
        unique case (rd_idx)
            FPM_IDX_DIV:  rd_val = r.div;
            FPM_IDX_SEC:  rd_val = r.sec;
            FPM_IDX_KCFG: rd_val = r.kcfg;
            FPM_IDX_PROT: rd_val = r.prot;
            FPM_IDX_STAT: rd_val = {2'b11, r.pviol, 5'h00};
            FPM_IDX_CMD:  rd_val = r.cmd;
            FPM_IDX_TAH:  rd_val = r.tah;
            FPM_IDX_TAL:  rd_val = r.tal;
            FPM_IDX_TDH:  rd_val = r.tdh;
            FPM_IDX_TDL:  rd_val = r.tdl;
            default:      rd_val = 8'h00;
        endcase
    end

    // CPU address to array page; only 0x4000-0xFFFF is mapped
    always_comb
    begin
        pg    = 3'h0;
        pg_ok = 1'b0;
        unique case (cpu_req.addr[15:14])
            2'b01:
            begin
                pg    = FPM_PG_LOW;
                pg_ok = 1'b1;
            end
            2'b10:
            begin
                // Window follows page select, 0x3A..0x3F only
                pg    = cpu_req.page[2:0];
                pg_ok = (cpu_req.page[7:3] == FPM_PS_BASE)
                      && (cpu_req.page[2:1] != FPM_PS_GAP);
            end
            2'b11:
            begin
                pg    = FPM_PG_TOP;
                pg_ok = 1'b1;
            end
            default:
            begin
                pg    = 3'h0;
                pg_ok = 1'b0;
            end
        endcase
        aa = {pg, cpu_req.addr[13:0]};
    end

    // Region hits on the array address, so paged views match too
    always_comb
    begin
        pr     = r.prot;
        lo_hit = (aa[16:14] == FPM_PG_LOW)
               && (aa[13:0] < FPM_LO_END[pr[1:0]]);
        hi_hit = (aa[16:14] == FPM_PG_TOP)
               && (aa[13:0] >= FPM_HI_BEG[pr[4:3]]);
        if (pr[FPM_PR_OPEN])
        begin
            prot_hit = (lo_hit && !pr[FPM_PR_LDIS])
                     || (hi_hit && !pr[FPM_PR_HDIS]);
        end
        else
        begin
            // Everything outside enabled lower/higher is locked;
            // both disabled means the whole array is locked
            prot_hit = !((lo_hit && !pr[FPM_PR_LDIS])
                     || (hi_hit && !pr[FPM_PR_HDIS]));
        end
    end

    // Next-state logic for every register of the block
    always_comb
    begin
        nxt = r;
        wv  = r.wdat;
        if (ce)
        begin
            // Reset sequence: fetch protection, then security byte
            unique case (r.rs)
                FPM_RS_ADDP:
                begin
                    nxt.cfg_re   = 1'b1;
                    nxt.cfg_addr = FPM_CFG_PROT;
                    nxt.rs       = FPM_RS_WTP;
                end
                FPM_RS_WTP:
                begin
                    nxt.cfg_re = 1'b0;
                    nxt.rs     = FPM_RS_GETP;
                end
                FPM_RS_GETP:
                begin
                    nxt.prot     = cfg_rd_data;
                    nxt.cfg_re   = 1'b1;
                    nxt.cfg_addr = FPM_CFG_SEC;
                    nxt.rs       = FPM_RS_WTS;
                end
                FPM_RS_WTS:
                begin
                    nxt.cfg_re = 1'b0;
                    nxt.rs     = FPM_RS_GETS;
                end
                FPM_RS_GETS:
                begin
                    nxt.sec  = cfg_rd_data;
                    nxt.hold = 1'b0;
                    nxt.rs   = FPM_RS_RUN;
                end
                FPM_RS_RUN:
                begin
                    nxt.cfg_re = 1'b0;
                end
                default:
                begin
                    nxt.rs = FPM_RS_ADDP;
                end
            endcase

            // CPU access to the array; nothing leaves the chip
            nxt.arr.sel    = cpu_req.valid && pg_ok && !r.hold;
            nxt.arr.we     = cpu_req.we;
            nxt.arr.addr   = aa;
            nxt.arr.viol   = nxt.arr.sel && cpu_req.we && prot_hit;
            // Key writes only while key access is armed
            nxt.arr.key_wr = nxt.arr.sel && cpu_req.we
                           && r.kcfg[FPM_KCFG_KEY]
                           && (aa[16:4] == FPM_KEY_HI)
                           && !aa[3]
                           && (aa[16:14] == FPM_KEY_TOP);

            // Write address and data channels, taken in either order
            if (s_axi_awvalid && r.awrdy)
            begin
                nxt.aw_got = 1'b1;
                nxt.aw_idx = s_axi_awaddr[5:2];
                nxt.aw_ok  = (s_axi_awaddr[AW-1:6] == '0);
            end
            if (s_axi_wvalid && r.wrdy)
            begin
                nxt.w_got = 1'b1;
                nxt.wdat  = s_axi_wdata[7:0];
                nxt.w_en  = s_axi_wstrb[0];
            end

            // Register write once both halves are in
            if (r.aw_got && r.w_got && !r.bvalid)
            begin
                nxt.aw_got = 1'b0;
                nxt.w_got  = 1'b0;
                nxt.bvalid = 1'b1;
                nxt.bresp  = r.aw_ok ? FPM_OKAY : FPM_SLVERR;
                if (r.aw_ok && r.w_en)
                begin
                    unique case (r.aw_idx)
                        FPM_IDX_DIV:
                        begin
                            // Low bits write once, top bit records it
                            if (!r.div[FPM_DIV_LD])
                            begin
                                nxt.div = {1'b1, wv[6:0]};
                            end
                        end
                        FPM_IDX_KCFG:
                        begin
                            nxt.kcfg = wv & FPM_KCFG_MASK;
                            if (r.sec[7:6] != FPM_KEY_ON)
                            begin
                                nxt.kcfg[FPM_KCFG_KEY] =
                                    r.kcfg[FPM_KCFG_KEY];
                            end
                        end
                        FPM_IDX_PROT:
                        begin
                            // Open and disable bits only drop; a size locks once its region is enabled
                            nxt.prot[FPM_PR_OPEN] =
                                r.prot[FPM_PR_OPEN] & wv[FPM_PR_OPEN];
                            nxt.prot[FPM_PR_HDIS] =
                                r.prot[FPM_PR_HDIS] & wv[FPM_PR_HDIS];
                            nxt.prot[FPM_PR_LDIS] =
                                r.prot[FPM_PR_LDIS] & wv[FPM_PR_LDIS];
                            if (r.prot[FPM_PR_HDIS])
                            begin
                                nxt.prot[4:3] = wv[4:3];
                            end
                            if (r.prot[FPM_PR_LDIS])
                            begin
                                nxt.prot[1:0] = wv[1:0];
                            end
                        end
                        FPM_IDX_STAT:
                        begin
                            if (wv[FPM_ST_PVIOL])
                            begin
                                nxt.pviol = 1'b0;
                            end
                        end
                        FPM_IDX_CMD:  nxt.cmd = wv & FPM_CMD_MASK;
                        FPM_IDX_TAH:  nxt.tah = wv;
                        FPM_IDX_TAL:  nxt.tal = wv;
                        FPM_IDX_TDH:  nxt.tdh = wv;
                        FPM_IDX_TDL:  nxt.tdl = wv;
                        default:
                        begin
                            nxt.tah = r.tah;
                        end
                    endcase
                end
            end

            // Violation set after any clear so a same-cycle event wins
            if (nxt.arr.viol)
            begin
                nxt.pviol = 1'b1;
            end

            if (r.bvalid && s_axi_bready)
            begin
                nxt.bvalid = 1'b0;
            end

            // Read channel: one read at a time, data one cycle later
            if (s_axi_arvalid && r.arrdy)
            begin
                nxt.rvalid = 1'b1;
                nxt.rdat   = rd_ok ? rd_val : 8'h00;
                nxt.rresp  = rd_ok ? FPM_OKAY : FPM_SLVERR;
            end
            else if (r.rvalid && s_axi_rready)
            begin
                nxt.rvalid = 1'b0;
            end

            // Ready flags registered so every output is a flop
            nxt.awrdy = !nxt.aw_got && !nxt.bvalid;
            nxt.wrdy  = !nxt.w_got && !nxt.bvalid;
            nxt.arrdy = !nxt.rvalid;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r          <= '0;
            r.rs       <= FPM_RS_ADDP;
            r.div      <= FPM_RST_DIV;
            r.sec      <= FPM_RST_SEC;
            r.kcfg     <= FPM_RST_KCFG;
            r.prot     <= FPM_RST_PROT;
            r.hold     <= 1'b1;
            r.cfg_addr <= FPM_CFG_PROT;
            r.bresp    <= FPM_OKAY;
            r.rresp    <= FPM_OKAY;
        end
        else
        begin
            r <= nxt;
        end
    end

    // Outputs straight from the state flops
    assign s_axi_awready = r.awrdy;
    assign s_axi_wready  = r.wrdy;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = r.arrdy;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rdata   = {24'h000000, r.rdat};
    assign arr_req       = r.arr;
    assign cpu_hold      = r.hold;
    assign cfg_re        = r.cfg_re;
    assign cfg_addr      = r.cfg_addr;

endmodule : fpm_top

// ---- tb/fpm_cfg_model.sv ----
// Stand-in for the array's configuration bytes read during reset.
// Assumes one fetch answer the cycle after the design raises cfg_re.
`timescale 1ns/1ps
module fpm_cfg_model
(
    input  wire logic        clk_sys,
    input  wire logic        cfg_re,
    input  wire logic [16:0] cfg_addr,
    input  wire logic [7:0]  prot_byte,
    input  wire logic [7:0]  sec_byte,
    output logic [7:0]       cfg_rd_data
);
    logic [7:0] data_r = 8'h00;

    // Outside a fetch the lines toggle, so a late sample reads garbage
    always_ff @(posedge clk_sys)
    begin
        if (cfg_re)
            data_r <= (cfg_addr == 17'h1ff0d) ? prot_byte
                    : (cfg_addr == 17'h1ff0f) ? sec_byte
                    : 8'hff;
        else
            data_r <= ~data_r;
    end

    assign cfg_rd_data = data_r;
endmodule : fpm_cfg_model

// ---- tb/fpm_top_sva.sv ----
// Checker for the page map block: CPU decode, reset load, bus reads.
// Sees the top module's ports only; bound to every instance of it.
`timescale 1ns/1ps
module fpm_top_sva
    import fpm_pkg::*;
#(
    parameter int AW = 8
)(
    input wire logic          clk_sys,
    input wire logic          sys_rst,
    input wire logic          ce,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic [1:0]    s_axi_rresp,
    input wire logic          s_axi_rvalid,
    input wire fpm_cpu_s      cpu_req,
    input wire fpm_arr_s      arr_req,
    input wire logic          cpu_hold,
    input wire logic          cfg_re,
    input wire logic [16:0]   cfg_addr
);
    // A frozen clock enable stalls everything, so checks pause too
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst || !ce);

    // Decode helpers
    logic       go;
    logic [1:0] qtr;
    logic       pg_ok;
    logic       rd_go;
    assign go    = cpu_req.valid && !cpu_hold;
    assign qtr   = cpu_req.addr[15:14];
    assign pg_ok = cpu_req.page >= 8'h3a && cpu_req.page <= 8'h3f;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    sequence seq_prot_fetch;
        cfg_re && cfg_addr == 17'h1ff0d;
    endsequence
    sequence seq_sec_fetch;
        cfg_re && cfg_addr == 17'h1ff0f;
    endsequence

    a_hold_blocks: assert property (cpu_hold |=> !arr_req.sel)
        else $error("cpu request passed during load");
    a_below_array: assert property (
        go && qtr == 2'b00 |=> !arr_req.sel)
        else $error("address below array selected");
    a_low_fixed: assert property (go && qtr == 2'b01 |=>
        arr_req.sel && arr_req.addr == {3'h6, $past(cpu_req.addr[13:0])})
        else $error("low fixed page wrong");
    a_top_fixed: assert property (go && qtr == 2'b11 |=>
        arr_req.sel && arr_req.addr == {3'h7, $past(cpu_req.addr[13:0])})
        else $error("top fixed page wrong");
    a_window_paged: assert property (go && qtr == 2'b10 && pg_ok |=>
        arr_req.sel && arr_req.addr == {$past(cpu_req.page[2:0]),
        $past(cpu_req.addr[13:0])})
        else $error("paged window wrong");
    a_window_off: assert property (
        go && qtr == 2'b10 && !pg_ok |=> !arr_req.sel)
        else $error("unknown page selected");
    a_rsvd_zero: assert property (rd_go && s_axi_araddr[7:6] == 2'b00 &&
        (s_axi_araddr[5:2] inside {4'h2, 4'h7} || s_axi_araddr[5:4] == 2'b11)
        |=> s_axi_rvalid && s_axi_rdata == 32'h0)
        else $error("reserved register not zero");
    a_map_limit: assert property (rd_go && s_axi_araddr[7:6] != 2'b00 |=>
        s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("read past register block not refused");
    a_load_order: assert property (
        seq_prot_fetch |=> !cfg_re ##1 seq_sec_fetch)
        else $error("config fetch order wrong");
    a_hold_release: assert property (
        seq_sec_fetch |=> cpu_hold ##1 !cpu_hold)
        else $error("cpu hold not released after load");
endmodule : fpm_top_sva

bind fpm_top fpm_top_sva #(.AW(AW)) fpm_top_sva_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .cpu_req(cpu_req), .arr_req(arr_req), .cpu_hold(cpu_hold),
    .cfg_re(cfg_re), .cfg_addr(cfg_addr)
);

// ---- tb/fpm_top_test.sv ----
// Bench for the page map block: bus tasks, CPU decode and regions.
// Assumes the config model answers the reset fetches.
`timescale 1ns/1ps
module fpm_top_test
    import fpm_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        cpu_hold, cfg_re;
    logic [16:0] cfg_addr;
    logic [7:0]  cfg_rd_data;
    logic [7:0]  prot_b = 8'hc4, sec_b = 8'h82;
    fpm_cpu_s    cpu_req = '0;
    fpm_arr_s    arr_req;
    int          failures = 0, checks_done = 0, i;
    logic        key_exp = 1'b0;

    always #4 clk_sys = ~clk_sys;

    // Clock enable and byte strobes held on: no write is masked by its strobe
    fpm_top fpm_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_req(cpu_req),
        .arr_req(arr_req), .cpu_hold(cpu_hold), .cfg_re(cfg_re),
        .cfg_addr(cfg_addr), .cfg_rd_data(cfg_rd_data));
    fpm_cfg_model fpm_cfg_model_inst (.clk_sys(clk_sys), .cfg_re(cfg_re),
        .cfg_addr(cfg_addr), .prot_byte(prot_b), .sec_byte(sec_b),
        .cfg_rd_data(cfg_rd_data));

    task automatic test_done;
    begin
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, g);
    begin
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    end
    endtask : chk

    // A spent wait counts as a mismatch and ends the run
    task automatic tmo(input int n);
    begin
        if (n >= 64)
        begin
            failures++;
            test_done;
        end
    end
    endtask : tmo

    task automatic axi_wr(input logic [7:0] a, d, input logic [1:0] er);
        int n;
    begin
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(n);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        int n;
    begin
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        tmo(n);
        chk($sformatf("rdata at %h", a), e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    end
    endtask : axi_rd

    // One CPU write; the decode stands in the cycle after it
    task automatic cpu(input logic [15:0] a, input logic [7:0] pg,
                       input logic s, v, input logic [16:0] ea);
    begin
        @(posedge clk_sys);
        cpu_req <= '{valid: 1'b1, we: 1'b1, addr: a, page: pg};
        @(posedge clk_sys);
        cpu_req.valid <= 1'b0;
        @(posedge clk_sys);
        chk("arr_sel", {31'h0, s}, {31'h0, arr_req.sel});
        if (s)
        begin
            chk("arr_addr", {15'h0, ea}, {15'h0, arr_req.addr});
            chk("arr_viol", {31'h0, v}, {31'h0, arr_req.viol});
            chk("arr_key", {31'h0, key_exp}, {31'h0, arr_req.key_wr});
        end
    end
    endtask : cpu

    task automatic do_reset;
        int n;
    begin
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (n = 0; n < 64 && cpu_hold !== 1'b0; n++) @(posedge clk_sys);
        tmo(n);
    end
    endtask : do_reset

    // Main sequence: load, map, decode, regions, second load
    initial
    begin
        do_reset;
        axi_rd(8'h04, 32'h82, 2'b00);
        axi_rd(8'h10, 32'hc4, 2'b00);
        axi_wr(8'h04, 8'h00, 2'b00);
        axi_rd(8'h04, 32'h82, 2'b00);
        // Divider takes one write only; command keeps its live bits
        axi_wr(8'h00, 8'h05, 2'b00);
        axi_wr(8'h00, 8'h7f, 2'b00);
        axi_rd(8'h00, 32'h85, 2'b00);
        axi_wr(8'h18, 8'hff, 2'b00);
        axi_rd(8'h18, 32'h65, 2'b00);
        for (i = 0; i < 16; i++)
        begin
            if (i inside {2, 7} || i >= 12)
            begin
                axi_wr({i[3:0], 2'b00}, 8'hff, 2'b00);
                axi_rd({i[3:0], 2'b00}, 32'h0, 2'b00);
            end
            else if (i >= 8)
            begin
                axi_wr({i[3:0], 2'b00}, 8'h50 + i[7:0], 2'b00);
                axi_rd({i[3:0], 2'b00}, 32'h50 + i, 2'b00);
            end
        end
        axi_rd(8'h40, 32'h0, 2'b10);
        for (i = 'h39; i <= 'h40; i++)
            cpu(16'h8123, i[7:0], i >= 'h3a && i <= 'h3f, 1'b0,
                {i[2:0], 14'h0123});
        cpu(16'h3fff, 8'h3a, 1'b0, 1'b0, 17'h0);
        cpu(16'h4000, 8'h3a, 1'b1, 1'b0, 17'h18000);
        cpu(16'hf7ff, 8'h3a, 1'b1, 1'b0, 17'h1f7ff);
        cpu(16'hf800, 8'h3a, 1'b1, 1'b1, 17'h1f800);
        cpu(16'hb800, 8'h3f, 1'b1, 1'b1, 17'h1f800);
        // Key access armed: only the eight key bytes are flagged
        axi_wr(8'h0c, 8'he0, 2'b00);
        axi_rd(8'h0c, 32'he0, 2'b00);
        key_exp = 1'b1;
        cpu(16'hff07, 8'h3a, 1'b1, 1'b1, 17'h1ff07);
        key_exp = 1'b0;
        cpu(16'hff08, 8'h3a, 1'b1, 1'b1, 17'h1ff08);
        axi_wr(8'h0c, 8'h00, 2'b00);
        // Violation is sticky until cleared by writing one
        axi_rd(8'h14, 32'he0, 2'b00);
        axi_wr(8'h14, 8'h20, 2'b00);
        axi_rd(8'h14, 32'hc0, 2'b00);
        // Lower region sized first, then enabled
        axi_wr(8'h10, 8'hc7, 2'b00);
        axi_wr(8'h10, 8'hc3, 2'b00);
        axi_rd(8'h10, 32'hc3, 2'b00);
        cpu(16'h5fff, 8'h3a, 1'b1, 1'b1, 17'h19fff);
        cpu(16'h6000, 8'h3a, 1'b1, 1'b0, 17'h1a000);
        // Open bit cleared: only the middle is locked
        axi_wr(8'h10, 8'h43, 2'b00);
        cpu(16'h6000, 8'h3a, 1'b1, 1'b1, 17'h1a000);
        cpu(16'h5fff, 8'h3a, 1'b1, 1'b0, 17'h19fff);
        cpu(16'hf800, 8'h3a, 1'b1, 1'b0, 17'h1f800);
        // Second load locks the whole array
        prot_b <= 8'h24;
        sec_b <= 8'h41;
        do_reset;
        axi_rd(8'h10, 32'h24, 2'b00);
        axi_rd(8'h04, 32'h41, 2'b00);
        // Key bit refused while the loaded security disables it
        axi_wr(8'h0c, 8'he0, 2'b00);
        axi_rd(8'h0c, 32'hc0, 2'b00);
        cpu(16'h4000, 8'h3a, 1'b1, 1'b1, 17'h18000);
        cpu(16'h8000, 8'h3c, 1'b1, 1'b1, 17'h10000);
        cpu(16'hc000, 8'h3a, 1'b1, 1'b1, 17'h1c000);
        test_done;
    end
endmodule : fpm_top_test
